// File: inc/sfx_regs.svh
`ifndef SFX_REGS_SVH
`define SFX_REGS_SVH
// ============================================================
// How it works
// - buffer up to 64 bytes of a received non-data frame first.
// - a failed frame reception exits to non-fatal error handling.
// - a frame longer than 64 bytes exits to fatal error handling.
// - with mux attached, capture the frame's port field, then check it.
// - set-device-bits with notification bit set passes the port check.
// - no outstanding command at that port gives invalid-port error.
// - a validated frame is acknowledged with R_OK.
// - register or PIO frame to an idle device is acked and ignored.
// - register frame while command list stopped goes to register update.
// - accepted frames are dispatched by their frame type, or to not-running if frame receive is off.
// - BIST frame goes to far-end loopback or test-ongoing.
// - reset command: sync escape until quiet, flag signature, transmit.
// - transmit sets busy, records slot, fetches unless prefetch is set, sends with table length.
// - X_RDY collision returns to the proper idle and retries later.
// - a started then failed transmit sets non-fatal error and retries.
// - R_OK from the device leads to command success.

// ============================================================
// register offsets (byte address low bits)
`define SFX_OFS_CTRL 8'h00
`define SFX_OFS_STATUS 8'h04
`define SFX_OFS_BUSY 8'h08
`define SFX_OFS_DRQ 8'h0C
`define SFX_OFS_OUTST 8'h10
`define SFX_OFS_ISSUE 8'h14
`define SFX_OFS_DMACNT 8'h18

// ============================================================
// control bits
`define SFX_CTRL_PMA 0
`define SFX_CTRL_RUN 1
`define SFX_CTRL_FRE 2
`define SFX_CTRL_FBS 3
`define SFX_CTRL_RST 4'h0

// ============================================================
// status fields
`define SFX_ST_EXIT 4:0
`define SFX_ST_TFBSY 8
`define SFX_ST_SIG 9
`define SFX_ST_NFERR 10
`define SFX_ST_FERR 11
`define SFX_ST_PORT 15:12
`define SFX_ST_SLOT 20:16
`define SFX_ST_ATAPI 21
`define SFX_ST_STATE 31:24

// ============================================================
// issue register fields
`define SFX_IS_SLOT 4:0
`define SFX_IS_DEV 11:8
`define SFX_IS_MUXPORT 15:12
`define SFX_IS_FRAMELEN 20:16
`define SFX_IS_ATAPI 24
`define SFX_IS_RESET 25
`define SFX_IS_PREF 26
`define SFX_IS_GO 31

// ============================================================
// frame layout and type codes
`define SFX_FIFO_DEPTH 7'h40
`define SFX_TYPE_BYTE 0
`define SFX_PMP_BYTE 1
`define SFX_NBIT_POS 7
`define SFX_BIST_BYTE 2
`define SFX_FEL_POS 7
`define SFX_FT_D2H 8'h34
`define SFX_FT_SDB 8'hA1
`define SFX_FT_DMAACT 8'h39
`define SFX_FT_DMASET 8'h41
`define SFX_FT_BIST 8'h58
`define SFX_FT_PIO 8'h5F
`define SFX_ZERO32 32'h0000_0000
`define SFX_ZERO16 16'h0000
`endif

// File: inc/sfx_pkg.sv
package sfx_pkg;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_NDR_ENTRY = 8'h02,
        ST_NDR_PMCHK = 8'h04,
        ST_NDR_ACCEPT = 8'h08,
        ST_CF_SYNC = 8'h10,
        ST_CF_XMIT = 8'h20,
        ST_CF_FETCH = 8'h40,
        ST_CF_SEND = 8'h80
    } sfx_state_e;

    typedef enum logic [4:0] {
        EX_NONE = 5'h00,
        EX_P_IDLE = 5'h01,
        EX_FB_IDLE = 5'h02,
        EX_ERR_NONFATAL = 5'h03,
        EX_ERR_FATAL = 5'h04,
        EX_INVALID_MUX_PORT_ERROR = 5'h05,
        EX_REGFIS_UPD = 5'h06,
        EX_NOT_RUNNING = 5'h07,
        EX_REGFIS = 5'h08,
        EX_SDB = 5'h09,
        EX_DMA_XMIT = 5'h0A,
        EX_DMA_SETUP = 5'h0B,
        EX_BIST_FEL = 5'h0C,
        EX_BIST_TEST = 5'h0D,
        EX_PIO = 5'h0E,
        EX_UNKNOWN = 5'h0F,
        EX_CFIS_SUCCESS = 5'h10,
        EX_ERR_SYNC_FB = 5'h11,
        EX_ERR_SYNC = 5'h12
    } sfx_exit_e;

    typedef struct packed {
        logic valid;
        logic last;
        logic err;
        logic [7:0] data;
    } sfx_rx_s;

    typedef struct packed {
        logic collision;
        logic sync_recv;
        logic rok;
        logic fail;
    } sfx_tx_status_s;
endpackage

// File: hw/sfx_port_fsm.sv
`include "sfx_regs.svh"

module sfx_port_fsm
    import sfx_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    // link receive side
    input wire sfx_rx_s rx_in,
    output logic r_ok_out,
    // link transmit side
    input wire logic link_quiet_in,
    input wire sfx_tx_status_s tx_status_in,
    output logic sync_escape_out,
    output logic tx_req_out,
    output logic [4:0] tx_len_out,
    // command frame fetch
    input wire logic fetch_done_in,
    output logic fetch_req_out,
    output logic [4:0] fetch_slot_out,
    // exit towards the remaining port states
    output logic exit_valid_out,
    output sfx_exit_e exit_code_out,
    output logic [3:0] current_mux_port_out
);

    // ============================================================
    // state
    sfx_state_e state, next_state;
    logic [7:0] fifo [0:63];
    logic [6:0] rx_cnt;
    logic rx_done, rx_err, rx_ovf;
    logic [3:0] ctrl;
    logic [15:0] busy_flags, drq_flags, outstanding;
    logic [31:0] issue;
    logic pending;
    logic taskfile_busy, sig_update, nf_err, f_err;
    logic [4:0] active_data_slot;
    logic atapi_transfer_flag;
    logic [31:0] dma_transfer_count;
    logic [3:0] current_mux_port;
    sfx_exit_e last_exit;
    logic exit_now;
    sfx_exit_e next_exit;

    // ============================================================
    // ahb decode
    logic ap_valid, dp_write, rd_wait;
    logic [7:0] dp_addr;
    wire pm_attached_setting = ctrl[`SFX_CTRL_PMA];
    wire cmd_list_run = ctrl[`SFX_CTRL_RUN];
    wire frame_receive_enable = ctrl[`SFX_CTRL_FRE];
    wire frame_switching_enable = ctrl[`SFX_CTRL_FBS];
    wire ap_take = hsel_in && htrans_in[1] && hready_in;
    wire wr_ctrl = dp_write && dp_addr == `SFX_OFS_CTRL;
    wire wr_status = dp_write && dp_addr == `SFX_OFS_STATUS;
    wire wr_busy = dp_write && dp_addr == `SFX_OFS_BUSY;
    wire wr_drq = dp_write && dp_addr == `SFX_OFS_DRQ;
    wire wr_outst = dp_write && dp_addr == `SFX_OFS_OUTST;
    wire in_cmd = state inside {ST_CF_SYNC, ST_CF_XMIT, ST_CF_FETCH, ST_CF_SEND};

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [31:0] r;
        r = `SFX_ZERO32;
        case (a)
            `SFX_OFS_CTRL: r[3:0] = ctrl;
            `SFX_OFS_STATUS: begin
                r[`SFX_ST_EXIT] = last_exit;
                r[`SFX_ST_TFBSY] = taskfile_busy;
                r[`SFX_ST_SIG] = sig_update;
                r[`SFX_ST_NFERR] = nf_err;
                r[`SFX_ST_FERR] = f_err;
                r[`SFX_ST_PORT] = current_mux_port;
                r[`SFX_ST_SLOT] = active_data_slot;
                r[`SFX_ST_ATAPI] = atapi_transfer_flag;
                r[`SFX_ST_STATE] = state;
            end
            `SFX_OFS_BUSY: r[15:0] = busy_flags;
            `SFX_OFS_DRQ: r[15:0] = drq_flags;
            `SFX_OFS_OUTST: r[15:0] = outstanding;
            `SFX_OFS_ISSUE: r = {pending, issue[30:0]};
            `SFX_OFS_DMACNT: r = dma_transfer_count;
            default: r = `SFX_ZERO32;
        endcase
        return r;
    endfunction

    // ============================================================
    // frame decode
    wire [7:0] ftype = fifo[`SFX_TYPE_BYTE];
    wire [3:0] fis_port = fifo[`SFX_PMP_BYTE][3:0];
    wire is_d2h = ftype == `SFX_FT_D2H;
    wire is_pio = ftype == `SFX_FT_PIO;
    wire is_sdb = ftype == `SFX_FT_SDB;
    wire notify = is_sdb && fifo[`SFX_PMP_BYTE][`SFX_NBIT_POS];
    wire far_loop = fifo[`SFX_BIST_BYTE][`SFX_FEL_POS];
    wire dev_idle = !busy_flags[current_mux_port] && !drq_flags[current_mux_port];
    wire [3:0] issuing_device = issue[`SFX_IS_DEV];
    // receive has priority in idle only: a frame arriving while a command is in progress is not taken
    wire rx_take = rx_in.valid && (state == ST_IDLE || (state == ST_NDR_ENTRY && !rx_done));
    wire tx_start = state == ST_IDLE && pending && !rx_in.valid;
    wire wr_issue = dp_write && dp_addr == `SFX_OFS_ISSUE && !in_cmd && !tx_start;
    wire [15:0] busy_set = state == ST_CF_XMIT ? 16'h0001 << issuing_device : `SFX_ZERO16;

    // ============================================================
    // next state
    always_comb begin
        next_state = state;
        exit_now = 1'b0;
        next_exit = EX_NONE;
        case (state)
            ST_IDLE: begin
                if (rx_in.valid) begin
                    next_state = ST_NDR_ENTRY;
                end else if (pending) begin
                    next_state = issue[`SFX_IS_RESET] ? ST_CF_SYNC : ST_CF_XMIT;
                end
            end
            ST_NDR_ENTRY: begin
                if (rx_done) begin
                    exit_now = rx_err || rx_ovf;
                    next_state = ST_IDLE;
                    if (rx_err) begin
                        next_exit = EX_ERR_NONFATAL;
                    end else if (rx_ovf) begin
                        next_exit = EX_ERR_FATAL;
                    end else if (pm_attached_setting) begin
                        next_state = ST_NDR_PMCHK;
                    end else begin
                        next_state = ST_NDR_ACCEPT;
                    end
                end
            end
            ST_NDR_PMCHK: begin
                next_state = ST_NDR_ACCEPT;
                if (notify) begin
                    next_state = ST_NDR_ACCEPT;
                end else if (!outstanding[fis_port]) begin
                    next_state = ST_IDLE;
                    exit_now = 1'b1;
                    next_exit = EX_INVALID_MUX_PORT_ERROR;
                end
            end
            ST_NDR_ACCEPT: begin
                next_state = ST_IDLE;
                exit_now = 1'b1;
                if ((is_d2h || is_pio) && dev_idle) begin
                    next_exit = EX_P_IDLE;
                end else if (is_d2h && !cmd_list_run) begin
                    next_exit = EX_REGFIS_UPD;
                end else if (!frame_receive_enable) begin
                    next_exit = EX_NOT_RUNNING;
                end else if (is_d2h) begin
                    next_exit = EX_REGFIS;
                end else if (is_sdb) begin
                    next_exit = EX_SDB;
                end else if (ftype == `SFX_FT_DMAACT) begin
                    next_exit = EX_DMA_XMIT;
                end else if (ftype == `SFX_FT_DMASET) begin
                    next_exit = EX_DMA_SETUP;
                end else if (ftype == `SFX_FT_BIST) begin
                    next_exit = far_loop ? EX_BIST_FEL : EX_BIST_TEST;
                end else if (is_pio) begin
                    next_exit = EX_PIO;
                end else begin
                    next_exit = EX_UNKNOWN;
                end
            end
            ST_CF_SYNC: begin
                if (link_quiet_in) begin
                    next_state = ST_CF_XMIT;
                end
            end
            ST_CF_XMIT: begin
                next_state = issue[`SFX_IS_PREF] ? ST_CF_SEND : ST_CF_FETCH;
            end
            ST_CF_FETCH: begin
                if (fetch_done_in) begin
                    next_state = ST_CF_SEND;
                end
            end
            ST_CF_SEND: begin
                exit_now = |tx_status_in;
                if (exit_now) begin
                    next_state = ST_IDLE;
                end
                if (tx_status_in.collision) begin
                    next_exit = frame_switching_enable ? EX_FB_IDLE : EX_P_IDLE;
                end else if (tx_status_in.sync_recv) begin
                    next_exit = frame_switching_enable ? EX_ERR_SYNC_FB : EX_ERR_SYNC;
                end else if (tx_status_in.rok) begin
                    next_exit = EX_CFIS_SUCCESS;
                end else if (tx_status_in.fail) begin
                    next_exit = EX_ERR_NONFATAL;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // ahb slave: reads take one wait state so a write just before is seen
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            dp_write <= 1'b0;
            dp_addr <= 8'h00;
            rd_wait <= 1'b0;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
            hrdata_out <= `SFX_ZERO32;
        end else begin
            dp_write <= ap_take && hwrite_in;
            rd_wait <= ap_take && !hwrite_in;
            hreadyout_out <= !(ap_take && !hwrite_in);
            if (ap_take) begin
                dp_addr <= haddr_in[7:0];
            end
            if (rd_wait) begin
                hrdata_out <= read_mux(dp_addr);
            end
        end
    end

    // ============================================================
    // receive buffer
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_cnt <= 7'h00;
            rx_done <= 1'b0;
            rx_err <= 1'b0;
            rx_ovf <= 1'b0;
        end else if (state == ST_IDLE && !rx_in.valid) begin
            rx_cnt <= 7'h00;
            rx_done <= 1'b0;
            rx_err <= 1'b0;
            rx_ovf <= 1'b0;
        end else if (rx_take) begin
            if (rx_cnt < `SFX_FIFO_DEPTH) begin
                fifo[rx_cnt[5:0]] <= rx_in.data;
                rx_cnt <= rx_cnt + 7'h01;
            end else begin
                rx_ovf <= 1'b1;
            end
            rx_done <= rx_in.last;
            rx_err <= rx_err || rx_in.err;
        end
    end

    // ============================================================
    // control and command registers
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl <= `SFX_CTRL_RST;
            drq_flags <= `SFX_ZERO16;
            outstanding <= `SFX_ZERO16;
            issue <= `SFX_ZERO32;
        end else begin
            if (wr_ctrl) ctrl <= hwdata_in[3:0];
            if (wr_drq) drq_flags <= hwdata_in[15:0];
            if (wr_outst) outstanding <= hwdata_in[15:0];
            if (wr_issue) issue <= hwdata_in;
        end
    end

    // hardware sets win over software clears in the same cycle
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            pending <= 1'b0;
            busy_flags <= `SFX_ZERO16;
            taskfile_busy <= 1'b0;
            sig_update <= 1'b0;
            nf_err <= 1'b0;
            f_err <= 1'b0;
        end else begin
            if (wr_issue) begin
                pending <= hwdata_in[`SFX_IS_GO];
            end else if (exit_now && next_exit inside {EX_CFIS_SUCCESS, EX_ERR_SYNC,
                                                       EX_ERR_SYNC_FB}) begin
                pending <= 1'b0;
            end
            busy_flags <= (wr_busy ? hwdata_in[15:0] : busy_flags) | busy_set;
            taskfile_busy <= (state == ST_CF_XMIT) ||
                (taskfile_busy && !(wr_status && hwdata_in[`SFX_ST_TFBSY]));
            sig_update <= (state == ST_CF_SYNC && link_quiet_in) ||
                (sig_update && !(wr_status && hwdata_in[`SFX_ST_SIG]));
            nf_err <= (exit_now && next_exit == EX_ERR_NONFATAL) ||
                (nf_err && !(wr_status && hwdata_in[`SFX_ST_NFERR]));
            f_err <= (exit_now && next_exit == EX_ERR_FATAL) ||
                (f_err && !(wr_status && hwdata_in[`SFX_ST_FERR]));
        end
    end

    // ============================================================
    // state, recorded command context, outputs
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= ST_IDLE;
            active_data_slot <= 5'h00;
            atapi_transfer_flag <= 1'b0;
            dma_transfer_count <= `SFX_ZERO32;
            current_mux_port <= 4'h0;
            last_exit <= EX_NONE;
        end else begin
            state <= next_state;
            if (state == ST_NDR_PMCHK) current_mux_port <= fis_port;
            // record slot, port, atapi, zero count
            if (state == ST_CF_XMIT) begin
                active_data_slot <= issue[`SFX_IS_SLOT];
                current_mux_port <= issue[`SFX_IS_MUXPORT];
                atapi_transfer_flag <= issue[`SFX_IS_ATAPI];
                dma_transfer_count <= `SFX_ZERO32;
            end
            if (exit_now) last_exit <= next_exit;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            r_ok_out <= 1'b0;
            sync_escape_out <= 1'b0;
            tx_req_out <= 1'b0;
            tx_len_out <= 5'h00;
            fetch_req_out <= 1'b0;
            fetch_slot_out <= 5'h00;
            exit_valid_out <= 1'b0;
            exit_code_out <= EX_NONE;
            current_mux_port_out <= 4'h0;
        end else begin
            r_ok_out <= next_state == ST_NDR_ACCEPT;
            sync_escape_out <= next_state == ST_CF_SYNC;
            // fetch then send with table length
            fetch_req_out <= next_state == ST_CF_FETCH;
            tx_req_out <= next_state == ST_CF_SEND;
            tx_len_out <= issue[`SFX_IS_FRAMELEN];
            fetch_slot_out <= issue[`SFX_IS_SLOT];
            exit_valid_out <= exit_now;
            exit_code_out <= exit_now ? next_exit : EX_NONE;
            current_mux_port_out <= current_mux_port;
        end
    end

    // ============================================================
    // checks
    rd_wait_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ap_take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    rx_fail_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_NDR_ENTRY && rx_done && rx_err
        |=> exit_valid_out && exit_code_out == EX_ERR_NONFATAL)
        else $error("failed reception not routed to non-fatal");
    rx_oversize_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_NDR_ENTRY && rx_done && !rx_err && rx_ovf
        |=> exit_valid_out && exit_code_out == EX_ERR_FATAL)
        else $error("oversize frame not fatal");
    pm_route_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_NDR_ENTRY && rx_done && !rx_err && !rx_ovf && pm_attached_setting
        |=> state == ST_NDR_PMCHK ##1 current_mux_port == $past(fis_port))
        else $error("port check or capture missed");
    notify_pass_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_NDR_PMCHK && notify |=> state == ST_NDR_ACCEPT)
        else $error("notification frame rejected");
    bad_port_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_NDR_PMCHK && !notify && !outstanding[fis_port]
        |=> exit_valid_out && exit_code_out == EX_INVALID_MUX_PORT_ERROR)
        else $error("invalid port not flagged");
    accept_ack_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_NDR_ACCEPT |-> r_ok_out ##1 !r_ok_out)
        else $error("R_OK not given once");
    sync_done_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_CF_SYNC && link_quiet_in |=> state == ST_CF_XMIT && sig_update)
        else $error("sync escape did not finish");
    xmit_mark_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_CF_XMIT |=> taskfile_busy && busy_flags[$past(issuing_device)]
        && dma_transfer_count == `SFX_ZERO32)
        else $error("transmit did not mark busy");
    collide_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_CF_SEND && tx_status_in.collision |=> exit_valid_out && pending
        && exit_code_out == ($past(frame_switching_enable) ? EX_FB_IDLE : EX_P_IDLE))
        else $error("collision handling wrong");
    success_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state == ST_CF_SEND && tx_status_in == 4'b0010
        |=> exit_code_out == EX_CFIS_SUCCESS && !pending)
        else $error("R_OK did not complete command");

endmodule

// File: bench/sfx_dev_model.sv
module sfx_dev_model
    import sfx_pkg::*;
(
    // clock and host requests
    input wire logic clk_in,
    input wire logic tx_req_in,
    input wire logic fetch_req_in,
    input wire logic sync_escape_in,
    // device answers
    output sfx_rx_s rx_out,
    output sfx_tx_status_s tx_status_out,
    output logic fetch_done_out,
    output logic link_quiet_out
);
    timeunit 1ns;
    timeprecision 1ps;
    sfx_tx_status_s reply = 4'h2;
    int q = 0;
    initial rx_out = '0;
    initial tx_status_out = '0;
    initial fetch_done_out = 1'b0;
    // ============================================================
    // link answers: one status pulse per frame, quiet after 3 escape cycles
    always @(posedge clk_in) begin
        tx_status_out <= (tx_req_in && tx_status_out == 0) ? reply : 4'h0;
        fetch_done_out <= fetch_req_in && !fetch_done_out;
        q <= sync_escape_in ? q + 1 : 0;
    end
    assign link_quiet_out = q >= 3;
    // released data lines show inverted junk, never the last byte
    task automatic send(input logic [7:0] b[$], input logic bad);
        foreach (b[i]) begin
            @(posedge clk_in);
            rx_out <= '{1'b1, i == b.size() - 1, bad, b[i]};
        end
        @(posedge clk_in);
        rx_out <= '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
    endtask
endmodule

// File: bench/sfx_port_fsm_tb.sv
module sfx_port_fsm_tb import sfx_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, reset_in = 1, hwrite_in = 0;
    logic [1:0] htrans_in = 2'h0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, rd, hrdata_out;
    logic hreadyout_out, r_ok_out, link_quiet_in, fetch_done_in, fetch_req_out;
    logic tx_req_out, sync_escape_out, exit_valid_out, hresp_out;
    logic [4:0] tx_len_out, fetch_slot_out;
    logic [3:0] current_mux_port_out;
    sfx_rx_s rx_in;
    sfx_tx_status_s tx_status_in;
    sfx_exit_e exit_code_out;
    int err_count = 0, n_checks = 0;
    always #2.5 clk_in = ~clk_in;
    sfx_port_fsm DUT(.clk_in, .reset_in, .hsel_in(1'b1), .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out, .hresp_out,
        .hrdata_out, .rx_in, .r_ok_out, .link_quiet_in, .tx_status_in, .sync_escape_out,
        .tx_req_out, .tx_len_out, .fetch_done_in, .fetch_req_out, .fetch_slot_out,
        .exit_valid_out, .exit_code_out, .current_mux_port_out);
    sfx_dev_model m(.clk_in, .tx_req_in(tx_req_out), .fetch_req_in(fetch_req_out),
        .sync_escape_in(sync_escape_out), .rx_out(rx_in), .tx_status_out(tx_status_in),
        .fetch_done_out(fetch_done_in), .link_quiet_out(link_quiet_in));
    // ============================================================
    // shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            err_count++;
            $display("[ERR] %0t seen %h exp %h", $time, s, x);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        htrans_in <= 2'h2;
        hwrite_in <= w;
        haddr_in <= {24'h0, a};
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic wx(input sfx_exit_e e, input logic k);
        int n = 0;
        logic r = 0;
        // wait one edge first: the previous exit pulse may still stand
        do begin
            @(posedge clk_in);
            #1;
            r = r | r_ok_out;
            n++;
        end while (exit_valid_out !== 1'b1 && n < 99);
        chk(exit_code_out, e);
        chk(r, k);
    endtask
    task automatic frm(input logic [7:0] t, b1, b2, input sfx_exit_e e, input logic k);
        m.send('{t, b1, b2}, 1'b0);
        wx(e, k);
    endtask
    task automatic cmd(input logic [31:0] w, input logic [3:0] r, input sfx_exit_e e);
        m.reply = r;
        bus(1, 8'h14, w);
        wx(e, 0);
    endtask
    task automatic retry;
        m.reply = 4'h2;
        wx(EX_CFIS_SUCCESS, 0);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ============================================================
    // scenarios
    task automatic s_dispatch;
        bus(1, 8'h00, 32'h4);
        bus(1, 8'h00, 32'h6);
        bus(1, 8'h08, 32'h1);
        frm(8'h34, 0, 0, EX_REGFIS, 1);
        frm(8'hA1, 0, 0, EX_SDB, 1);
        frm(8'h39, 0, 0, EX_DMA_XMIT, 1);
        frm(8'h41, 0, 0, EX_DMA_SETUP, 1);
        frm(8'h58, 0, 8'h80, EX_BIST_FEL, 1);
        frm(8'h58, 0, 8'h00, EX_BIST_TEST, 1);
        frm(8'h5F, 0, 0, EX_PIO, 1);
        frm(8'h27, 0, 0, EX_UNKNOWN, 1);
        bus(1, 8'h08, 32'h0);
        frm(8'h34, 0, 0, EX_P_IDLE, 1);
        frm(8'h5F, 0, 0, EX_P_IDLE, 1);
        bus(1, 8'h0C, 32'h1);
        frm(8'h34, 0, 0, EX_REGFIS, 1);
        bus(1, 8'h08, 32'h1);
        bus(1, 8'h00, 32'h4);
        frm(8'h34, 0, 0, EX_REGFIS_UPD, 1);
        bus(1, 8'h00, 32'h0);
        frm(8'hA1, 0, 0, EX_NOT_RUNNING, 1);
    endtask
    task automatic s_rx_faults;
        logic [7:0] q[$];
        repeat (64) q.push_back(8'hA1);
        m.send('{8'h34, 8'h0}, 1'b1);
        wx(EX_ERR_NONFATAL, 0);
        m.send(q, 1'b0);
        wx(EX_NOT_RUNNING, 1);
        q.push_back(8'hA1);
        m.send(q, 1'b0);
        wx(EX_ERR_FATAL, 0);
        bus(0, 8'h40, 32'h0);
        chk(rd, 0);
    endtask
    task automatic s_mux;
        bus(1, 8'h00, 32'h7);
        bus(1, 8'h10, 32'h0);
        frm(8'hA1, 8'h83, 0, EX_SDB, 1);
        chk(current_mux_port_out, 4'h3);
        frm(8'hA1, 8'h05, 0, EX_INVALID_MUX_PORT_ERROR, 0);
        bus(1, 8'h10, 32'h20);
        frm(8'hA1, 8'h05, 0, EX_SDB, 1);
    endtask
    task automatic s_cmd;
        bus(1, 8'h00, 32'h6);
        cmd(32'h8205_0003, 4'h2, EX_CFIS_SUCCESS);
        chk({hresp_out, fetch_slot_out, tx_len_out}, {1'b0, 5'h03, 5'h05});
        bus(0, 8'h04, 32'h0);
        chk({rd[20:16], rd[9:8]}, 7'h0F);
        bus(0, 8'h18, 32'h0);
        chk(rd, 0);
        cmd(32'h8405_0003, 4'h8, EX_P_IDLE);
        retry();
        cmd(32'h8405_0003, 4'h1, EX_ERR_NONFATAL);
        retry();
        cmd(32'h8405_0003, 4'h4, EX_ERR_SYNC);
        bus(1, 8'h00, 32'hE);
        cmd(32'h8405_0003, 4'h8, EX_FB_IDLE);
        retry();
        cmd(32'h8405_0003, 4'h4, EX_ERR_SYNC_FB);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        reset_in <= 0;
        s_dispatch();
        s_rx_faults();
        s_mux();
        s_cmd();
        report_and_stop();
    end
    initial begin
        #50us;
        err_count++;
        report_and_stop();
    end
endmodule
